// file: rtl/spc_cfg.svh
// Register offsets, field positions, reset values, data-size limits and clock rate
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH
`define SPC_OFS_FRAME 6'h00
`define SPC_OFS_IRQDMA 6'h04
`define SPC_OFS_STATUS 6'h08
`define SPC_OFS_EVENT 6'h0c
`define SPC_FRAME_RST 16'h0000
`define SPC_IRQDMA_RST 16'h0000
`define SPC_STATUS_RST 16'h0002
`define SPC_CS_PHA 0
`define SPC_CS_POL 1
`define SPC_CS_MST 2
`define SPC_CS_DIV 3
`define SPC_CS_EN 6
`define SPC_CS_LSB 7
`define SPC_CS_SSL 8
`define SPC_CS_SSM 9
`define SPC_CS_RO 10
`define SPC_CS_W16 11
`define SPC_CS_CNX 12
`define SPC_CS_CEN 13
`define SPC_CS_DIR 14
`define SPC_CS_SLS 15
`define SPC_C1_RXD 0
`define SPC_C1_TXD 1
`define SPC_C1_SOE 2
`define SPC_C1_SPE 3
`define SPC_C1_FPE 4
`define SPC_C1_EIE 5
`define SPC_C1_RIE 6
`define SPC_C1_TIE 7
`define SPC_C1_DZ 8
`define SPC_C1_BYT 12
`define SPC_C1_RXO 13
`define SPC_C1_TXO 14
`define SPC_ST_RDY 0
`define SPC_ST_EMP 1
`define SPC_ST_URN 3
`define SPC_ST_CRC 4
`define SPC_ST_CFG 5
`define SPC_ST_OVR 6
`define SPC_ST_BSY 7
`define SPC_MIN_DZ 4'h3
`define SPC_DZ_FORCED 4'h7
`define SPC_CLK_MHZ 10
`endif

// file: rtl/spc_pkg.sv
// Types shared by the control block
package spc_pkg;
  typedef struct packed {
    logic [31:0] address;
    logic read;
    logic write;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } spc_req_s;
  typedef struct packed {
    logic [31:0] readdata;
    logic waitrequest;
  } spc_rsp_s;
  typedef struct packed {
    logic tx_empty_flag;
    logic rx_ready_flag;
    logic checksum_error_flag;
    logic config_fault_flag;
    logic rx_overrun_flag;
    logic tx_underrun_flag;
    logic busy;
    logic [2:0] rx_fifo_level;
  } spc_evt_s;
  typedef struct packed {
    logic sclk;
    logic sclk_oe;
    logic mosi_oe;
    logic miso_oe;
    logic sel;
    logic sel_oe;
  } spc_pin_s;
  typedef enum logic [1:0] {SPC_IDLE, SPC_ACK} spc_bus_e;
endpackage

// file: rtl/spc_control.sv
// Control and configuration block of the serial peripheral
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "spc_cfg.svh"
module spc_control
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire spc_pkg::spc_req_s avs_req,
  output spc_pkg::spc_rsp_s avs_rsp,
  input wire spc_pkg::spc_evt_s evt,
  input wire logic sel_pin_in,
  input wire logic sel_pin_is_output,
  input wire logic data_written,
  input wire logic dma_mode,
  output spc_pkg::spc_pin_s pins,
  output logic irq,
  output logic tx_dma_req,
  output logic rx_dma_req,
  output logic sel_level,
  output logic checksum_active,
  output logic checksum_16,
  output logic checksum_send,
  output logic lsb_first,
  output logic frame_pulse_active,
  output logic select_pulse_active,
  output logic [4:0] frame_bits,
  output logic [8:0] sclk_divisor,
  output logic capture_second_edge
);
  import spc_pkg::*;
  // ****************************************
  // Registers
  // ****************************************
  logic [15:0] frame_config;
  logic [15:0] irq_dma_control;
  logic [15:0] next_frame_config;
  logic [15:0] next_irq_dma_control;
  spc_bus_e bus_state;
  spc_bus_e next_bus_state;
  logic [31:0] next_readdata;
  logic [31:0] readdata;
  logic cs_cnx_sent;
  logic next_cs_cnx_sent;
  logic waitreq;
  logic next_waitreq;
  logic [15:0] status_word;
  logic rx_ready_eff;
  logic [3:0] dz_eff;
  logic sel_int;
  logic enabled;
  logic hit_wr;
  logic [15:0] wdata;
  // ****************************************
  // Derived state
  // ****************************************
  assign enabled = frame_config[`SPC_CS_EN];
  assign rx_ready_eff = irq_dma_control[`SPC_C1_BYT] ? (evt.rx_fifo_level >= 3'h1)
    : (evt.rx_fifo_level >= 3'h2);
  assign dz_eff = (irq_dma_control[`SPC_C1_DZ +: 4] < `SPC_MIN_DZ) ? `SPC_DZ_FORCED
    : irq_dma_control[`SPC_C1_DZ +: 4];
  assign sel_int = frame_config[`SPC_CS_SSM] ? frame_config[`SPC_CS_SSL] : sel_pin_in;
  always_comb
  begin
    status_word = 16'h0000;
    status_word[`SPC_ST_RDY] = rx_ready_eff | evt.rx_ready_flag;
    status_word[`SPC_ST_EMP] = evt.tx_empty_flag;
    status_word[`SPC_ST_URN] = evt.tx_underrun_flag;
    status_word[`SPC_ST_CRC] = evt.checksum_error_flag;
    status_word[`SPC_ST_CFG] = evt.config_fault_flag;
    status_word[`SPC_ST_OVR] = evt.rx_overrun_flag;
    status_word[`SPC_ST_BSY] = evt.busy;
  end
  // ****************************************
  // Avalon slave
  // ****************************************
  assign hit_wr = (bus_state == SPC_ACK) && avs_req.write;
  assign wdata = {avs_req.byteenable[1] ? avs_req.writedata[15:8] : 8'h00,
    avs_req.byteenable[0] ? avs_req.writedata[7:0] : 8'h00};
  always_comb
  begin
    next_bus_state = bus_state;
    next_frame_config = frame_config;
    next_irq_dma_control = irq_dma_control;
    next_readdata = readdata;
    next_cs_cnx_sent = cs_cnx_sent;
    unique case (bus_state)
      SPC_IDLE:
      begin
        if (avs_req.read || avs_req.write)
        begin
          next_bus_state = SPC_ACK;
          next_readdata = 32'h00000000;
          if (avs_req.read)
          begin
            unique case (avs_req.address[5:0])
              `SPC_OFS_FRAME: next_readdata = {16'h0000, frame_config};
              `SPC_OFS_IRQDMA: next_readdata = {16'h0000, irq_dma_control};
              `SPC_OFS_STATUS: next_readdata = {16'h0000, status_word};
              default: next_readdata = 32'h00000000;
            endcase
          end
        end
      end
      SPC_ACK:
      begin
        next_bus_state = SPC_IDLE;
        // Write lands at the edge that completes the transfer
        if (hit_wr && avs_req.address[5:0] == `SPC_OFS_FRAME)
        begin
          next_frame_config = wdata;
          if (dma_mode)
          begin
            next_frame_config[`SPC_CS_CNX] = 1'b0;
          end
        end
        if (hit_wr && avs_req.address[5:0] == `SPC_OFS_IRQDMA)
        begin
          next_irq_dma_control[12:0] = wdata[12:0];
          if (!enabled)
          begin
            next_irq_dma_control[14:13] = wdata[14:13];
          end
        end
      end
      default:
      begin
        next_bus_state = SPC_IDLE;
      end
    endcase
    // checksum-next consumed once the word it follows is shifted
    if (frame_config[`SPC_CS_CNX] && data_written)
    begin
      next_cs_cnx_sent = 1'b1;
    end
    else if (!frame_config[`SPC_CS_CNX])
    begin
      next_cs_cnx_sent = 1'b0;
    end
    next_waitreq = (next_bus_state == SPC_IDLE);
  end
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bus_state <= SPC_IDLE;
      frame_config <= `SPC_FRAME_RST;
      irq_dma_control <= `SPC_IRQDMA_RST;
      readdata <= 32'h00000000;
      cs_cnx_sent <= 1'b0;
      waitreq <= 1'b1;
    end
    else
    begin
      bus_state <= next_bus_state;
      frame_config <= next_frame_config;
      irq_dma_control <= next_irq_dma_control;
      readdata <= next_readdata;
      cs_cnx_sent <= next_cs_cnx_sent;
      waitreq <= next_waitreq;
    end
  end
  assign avs_rsp = {readdata, waitreq};
  // ****************************************
  // Registered outputs
  // ****************************************
  spc_pin_s next_pins;
  logic next_irq;
  logic next_txd;
  logic next_rxd;
  logic next_sel;
  logic [8:0] next_div;
  logic [4:0] next_bits;
  always_comb
  begin
    next_pins = '0;
    next_pins.sclk = frame_config[`SPC_CS_POL];
    next_pins.sclk_oe = enabled && frame_config[`SPC_CS_MST];
    if (frame_config[`SPC_CS_SLS])
    begin
      next_pins.mosi_oe = enabled && frame_config[`SPC_CS_MST] && frame_config[`SPC_CS_DIR];
      next_pins.miso_oe = enabled && !frame_config[`SPC_CS_MST] && frame_config[`SPC_CS_DIR];
    end
    else
    begin
      next_pins.mosi_oe = enabled && frame_config[`SPC_CS_MST] && !frame_config[`SPC_CS_RO];
      next_pins.miso_oe = enabled && !frame_config[`SPC_CS_MST] && !frame_config[`SPC_CS_RO];
    end
    next_pins.sel = 1'b0;
    next_pins.sel_oe = enabled && frame_config[`SPC_CS_MST] &&
      irq_dma_control[`SPC_C1_SOE] && sel_pin_is_output;
    next_irq = (irq_dma_control[`SPC_C1_TIE] && evt.tx_empty_flag) ||
      (irq_dma_control[`SPC_C1_RIE] && status_word[`SPC_ST_RDY]) ||
      (irq_dma_control[`SPC_C1_EIE] && (evt.checksum_error_flag ||
      evt.config_fault_flag || evt.rx_overrun_flag || evt.tx_underrun_flag));
    next_txd = irq_dma_control[`SPC_C1_TXD] && evt.tx_empty_flag;
    next_rxd = irq_dma_control[`SPC_C1_RXD] && status_word[`SPC_ST_RDY];
    // frame-pulse mode ignores the soft select
    next_sel = irq_dma_control[`SPC_C1_FPE] ? sel_pin_in : sel_int;
    next_div = 9'(9'h002 << frame_config[`SPC_CS_DIV +: 3]);
    next_bits = frame_config[`SPC_CS_W16] ? 5'h10 : {1'b0, dz_eff} + 5'h01;
  end
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pins <= '0;
      irq <= 1'b0;
      tx_dma_req <= 1'b0;
      rx_dma_req <= 1'b0;
      sel_level <= 1'b1;
      checksum_active <= 1'b0;
      checksum_16 <= 1'b0;
      checksum_send <= 1'b0;
      lsb_first <= 1'b0;
      frame_pulse_active <= 1'b0;
      select_pulse_active <= 1'b0;
      frame_bits <= 5'h08;
      sclk_divisor <= 9'h002;
      capture_second_edge <= 1'b0;
    end
    else
    begin
      pins <= next_pins;
      irq <= next_irq;
      tx_dma_req <= next_txd;
      rx_dma_req <= next_rxd;
      sel_level <= next_sel;
      checksum_active <= enabled && frame_config[`SPC_CS_CEN];
      checksum_16 <= frame_config[`SPC_CS_W16];
      checksum_send <= frame_config[`SPC_CS_CEN] && (cs_cnx_sent || frame_config[`SPC_CS_CNX]);
      lsb_first <= frame_config[`SPC_CS_LSB] && !irq_dma_control[`SPC_C1_FPE];
      frame_pulse_active <= irq_dma_control[`SPC_C1_FPE];
      select_pulse_active <= irq_dma_control[`SPC_C1_SPE];
      frame_bits <= next_bits;
      sclk_divisor <= next_div;
      capture_second_edge <= frame_config[`SPC_CS_PHA];
    end
  end
endmodule
`default_nettype wire

// file: verif/spc_control_chk.sv
// Port assertions for the control block
`timescale 1ns/1ns
`default_nettype none
module spc_control_chk
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire spc_pkg::spc_req_s avs_req,
  input wire spc_pkg::spc_rsp_s avs_rsp,
  input wire spc_pkg::spc_evt_s evt,
  input wire logic sel_pin_is_output,
  input wire spc_pkg::spc_pin_s pins,
  input wire logic irq,
  input wire logic tx_dma_req,
  input wire logic rx_dma_req,
  input wire logic [8:0] sclk_divisor
);
  import spc_pkg::*;
  wire logic rq = avs_req.read | avs_req.write;
  wire logic rxc = evt.rx_ready_flag | (evt.rx_fifo_level != 3'h0);
  wire logic anyc = evt.tx_empty_flag | rxc | evt.checksum_error_flag
    | evt.config_fault_flag | evt.rx_overrun_flag | evt.tx_underrun_flag;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // ********************
  // Bus and outputs
  // ********************
  sequence s_ack;
    !avs_rsp.waitrequest ##1 avs_rsp.waitrequest;
  endsequence
  a_bus_answer: assert property (rq && avs_rsp.waitrequest |=> s_ack)
    else $error("no answer");
  a_ack_cause: assert property (!avs_rsp.waitrequest |-> $past(rq))
    else $error("stray answer");
  a_tx_dma_cause: assert property (tx_dma_req |-> $past(evt.tx_empty_flag)
    || $past(evt.tx_empty_flag, 2)) else $error("stray tx dma");
  a_rx_dma_cause: assert property (rx_dma_req |-> $past(rxc) || $past(rxc, 2))
    else $error("stray rx dma");
  a_irq_cause: assert property (irq |-> $past(anyc) || $past(anyc, 2))
    else $error("stray irq");
  a_sel_drive: assert property (pins.sel_oe |-> !pins.sel &&
    ($past(sel_pin_is_output) || $past(sel_pin_is_output, 2))) else $error("bad select");
  a_div_legal: assert property ($onehot(sclk_divisor) && !sclk_divisor[0])
    else $error("bad divisor");
  a_sclk_steady: assert property ($changed(pins.sclk) |->
    $past(avs_req.write) || $past(avs_req.write, 2)) else $error("clock moved");
endmodule
bind spc_control spc_control_chk u_chk (.core_clk, .resetn, .avs_req, .avs_rsp, .evt,
  .sel_pin_is_output, .pins, .irq, .tx_dma_req, .rx_dma_req, .sclk_divisor);
`default_nettype wire

// file: verif/spc_far_dev.sv
// Far serial device model driving status and select pin
`timescale 1ns/1ns
`default_nettype none
module spc_far_dev
(
  input wire logic [9:0] flags,
  input wire logic pull_low,
  output spc_pkg::spc_evt_s evt,
  output logic sel_pin_in
);
  import spc_pkg::*;
  // Buffer state; transmit side empty while idle
  assign evt = spc_evt_s'(flags);
  // Select pin held high unless pulled low on purpose
  assign sel_pin_in = !pull_low;
endmodule
`default_nettype wire

// file: verif/tb_spc_control_config.sv
// Self-checking bench for the control block
`timescale 1ns/1ns
`default_nettype none
module tb_spc_control_config;
  import spc_pkg::*;
  logic core_clk, resetn, pl, so, dw, dm, irq, sel_level, txr, rxr, cka, c16, cks, lsb, fp, sp;
  logic cse;
  logic [9:0] fl;
  logic [31:0] rd;
  logic [4:0] fb;
  logic [8:0] dv;
  int errors, checks;
  spc_req_s rq;
  spc_rsp_s rs;
  spc_evt_s evt;
  spc_pin_s pins;
  logic si;
  spc_far_dev far (.flags(fl), .pull_low(pl), .evt, .sel_pin_in(si));
  spc_control dut (.core_clk, .resetn, .avs_req(rq), .avs_rsp(rs), .evt, .sel_pin_in(si),
    .sel_pin_is_output(so), .data_written(dw), .dma_mode(dm), .pins, .irq,
    .tx_dma_req(txr), .rx_dma_req(rxr), .sel_level, .checksum_active(cka),
    .checksum_16(c16), .checksum_send(cks), .lsb_first(lsb), .frame_pulse_active(fp),
    .select_pulse_active(sp), .frame_bits(fb), .sclk_divisor(dv), .capture_second_edge(cse));
  // ********************
  // Shared tasks
  // ********************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d);
    int n;
    rq.address <= {26'h0, a};
    rq.writedata <= {16'h0, d};
    rq.write <= w;
    rq.read <= !w;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (rs.waitrequest && n < 20);
    rd = rs.readdata;
    rq.write <= 1'b0;
    rq.read <= 1'b0;
    repeat (2) @(posedge core_clk);
    if (n >= 20)
    begin
      errors++;
      $display("[ERR] %0t bus hang", $time);
      summarize();
    end
  endtask
  task automatic t_cfg();
    logic [18:0] lm [8];
    lm = '{19'h50044, 19'h40444, 19'h5c044, 19'h48044, 19'h20040, 19'h00440, 19'h2c040,
      19'h08040};
    bus(0, 6'h08, 16'h0);
    chk(rd, 32'h2);
    chk({sel_level, fb, dv}, {1'b1, 5'h08, 9'h002});
    bus(1, 6'h3c, 16'hffff);
    bus(0, 6'h3c, 16'h0);
    chk(rd, 32'h0);
    for (int c = 0; c < 8; c++)
    begin
      bus(1, 6'h00, 16'h28c6 | 16'(c << 3));
      bus(0, 6'h00, 16'h0);
      chk(rd, 32'h28c6 | (c << 3));
      chk(dv, 9'h002 << c);
      chk({pins.sclk, cka, lsb, c16}, 4'hf);
    end
    bus(1, 6'h00, 16'h0001);
    chk(cse, 1'b1);
    bus(1, 6'h00, 16'h0);
    chk({pins.sclk, cka, lsb, c16, cse}, 5'h0);
    foreach (lm[i])
    begin
      bus(1, 6'h00, lm[i][15:0]);
      chk({pins.sclk_oe, pins.miso_oe, pins.mosi_oe}, lm[i][18:16]);
    end
    dm <= 1'b1;
    bus(1, 6'h00, 16'h3000);
    bus(0, 6'h00, 16'h0);
    chk({rd, cks}, {32'h2000, 1'b0});
    dm <= 1'b0;
    dw <= 1'b1;
    bus(1, 6'h00, 16'h3000);
    dw <= 1'b0;
    bus(0, 6'h00, 16'h0);
    chk({rd, cks}, {32'h3000, 1'b1});
    $display("test config done");
  endtask
  task automatic t_sel();
    bus(1, 6'h00, 16'h0040);
    pl <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(sel_level, 1'b0);
    pl <= 1'b0;
    bus(1, 6'h00, 16'h0244);
    chk(sel_level, 1'b0);
    bus(1, 6'h00, 16'h0344);
    chk(sel_level, 1'b1);
    so <= 1'b1;
    bus(1, 6'h04, 16'h0004);
    chk({pins.sel_oe, pins.sel}, 2'h2);
    so <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(pins.sel_oe, 1'b0);
    $display("test select done");
  endtask
  task automatic t_evt();
    logic [12:0] ev [9];
    ev = '{13'h1006, 13'h0000, 13'h0008, 13'h0015, 13'h0805, 13'h0404, 13'h0204,
      13'h0104, 13'h0084};
    bus(1, 6'h04, 16'h00fb);
    chk({fp, sp}, 2'h3);
    foreach (ev[i])
    begin
      fl <= ev[i][12:3];
      repeat (3) @(posedge core_clk);
      chk({irq, txr, rxr}, ev[i][2:0]);
      bus(0, 6'h08, 16'h0);
      chk(rd[1:0], ev[i][1:0]);
    end
    bus(1, 6'h04, 16'h10fb);
    fl <= 10'h001;
    repeat (3) @(posedge core_clk);
    chk({irq, rxr}, 2'h3);
    bus(1, 6'h04, 16'h0);
    fl <= 10'h3f0;
    repeat (3) @(posedge core_clk);
    chk({irq, txr, rxr, fp, sp}, 5'h0);
    fl <= 10'h200;
    $display("test events done");
  endtask
  task automatic t_size();
    bus(1, 6'h04, 16'h6000);
    bus(0, 6'h04, 16'h0);
    chk(rd, 32'h0);
    bus(1, 6'h00, 16'h0);
    bus(1, 6'h04, 16'h6000);
    bus(0, 6'h04, 16'h0);
    chk(rd, 32'h6000);
    for (int d = 0; d < 16; d++)
    begin
      bus(1, 6'h04, 16'(d << 8));
      chk(fb, d < 3 ? 8 : d + 1);
    end
    $display("test size done");
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial
  begin
    resetn = 1'b0;
    rq = spc_req_s'(70'h3 << 32);
    fl = 10'h200;
    {pl, so, dw, dm} = 4'h0;
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    t_cfg();
    t_sel();
    t_evt();
    t_size();
    summarize();
  end
endmodule
`default_nettype wire
